// *** design/sfs_pkg.sv ***
/*
  Package for the servo fault supervisor: register map, field layout, fault codes.
  Assumes a 32-bit AXI4-Lite register bus and a 100 MHz control clock.
*/
package sfs_pkg;
  // *****
  // Register byte offsets
  // *****
  localparam logic [7:0] SFS_CTRL_OFS   = 8'h00;
  localparam logic [7:0] SFS_STATUS_OFS = 8'h04;
  localparam logic [7:0] SFS_CODE_OFS   = 8'h08;
  localparam logic [7:0] SFS_SYNC_OFS   = 8'h0C;
  localparam logic [7:0] SFS_STALL_OFS  = 8'h10;
  localparam logic [7:0] SFS_SPEED_OFS  = 8'h14;
  localparam logic [7:0] SFS_BRAKE_OFS  = 8'h18;
  localparam logic [7:0] SFS_HOME_OFS   = 8'h1C;
  localparam logic [7:0] SFS_HEAT_OFS   = 8'h20;
  localparam int         SFS_ADDR_W     = 8;

  // *****
  // Control register fields
  // *****
  localparam int SFS_CTRL_RESET_BIT = 0;
  localparam int SFS_CTRL_ABS_BIT   = 1;

  // *****
  // Fault numbering
  // *****
  localparam int SFS_NFAULT = 11;
  localparam int SFS_F_SYNC  = 0;
  localparam int SFS_F_STALL = 1;
  localparam int SFS_F_BRAKE = 2;
  localparam int SFS_F_FWD   = 3;
  localparam int SFS_F_REV   = 4;
  localparam int SFS_F_ORG   = 5;
  localparam int SFS_F_BUS   = 6;
  localparam int SFS_F_MODE  = 7;
  localparam int SFS_F_TURN  = 8;
  localparam int SFS_F_BATT  = 9;
  localparam int SFS_F_SPARE = 10;

  localparam logic [9:0] SFS_CODE_NONE  = 10'h000;
  localparam logic [9:0] SFS_CODE_SYNC  = 10'h217;
  localparam logic [9:0] SFS_CODE_STALL = 10'h219;
  localparam logic [9:0] SFS_CODE_BRAKE = 10'h220;
  localparam logic [9:0] SFS_CODE_FWD   = 10'h221;
  localparam logic [9:0] SFS_CODE_REV   = 10'h222;
  localparam logic [9:0] SFS_CODE_ORG   = 10'h223;
  localparam logic [9:0] SFS_CODE_BUS   = 10'h224;
  localparam logic [9:0] SFS_CODE_MODE  = 10'h225;
  localparam logic [9:0] SFS_CODE_TURN  = 10'h226;
  localparam logic [9:0] SFS_CODE_BATT  = 10'h227;

  // *****
  // Reset values and bus response codes
  // *****
  localparam logic [31:0] SFS_SYNC_RST  = 32'h0000_0000;
  localparam logic [15:0] SFS_STALL_RST = 16'h0000;
  localparam logic [7:0]  SFS_COEF_RST  = 8'h32;
  localparam logic [31:0] SFS_ZERO32    = 32'h0000_0000;
  localparam logic [1:0]  SFS_RESP_OK   = 2'b00;
  localparam logic [1:0]  SFS_RESP_ERR  = 2'b10;

  // *****
  // Time base
  // *****
  localparam int SFS_CLK_MHZ   = 100;
  localparam int SFS_MS_NS     = 1000000;
  localparam int SFS_CLK_NS    = 1000 / SFS_CLK_MHZ;
  localparam int SFS_MS_CYCLES = SFS_MS_NS / SFS_CLK_NS;

  typedef enum logic [1:0] {
    SFS_BUS_IDLE = 2'b00,
    SFS_BUS_RESP = 2'b01
  } sfs_bus_t;
endpackage

// *** design/sfs_sticky.sv ***
/*
  One latched fault bit: set by its condition, cleared by a fault reset only
  once the condition is gone. Assumes one clock and a synchronous reset.
*/
module sfs_sticky (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic cond,
  input  wire logic fault_reset,
  output logic      flag
);
  typedef struct packed {
    logic flag;
  } sfs_sticky_t;

  sfs_sticky_t s_q;
  sfs_sticky_t s_d;

  always_comb begin
    s_d = s_q;
    if (cond) begin
      s_d.flag = 1'b1;
    end else if (fault_reset) begin
      s_d.flag = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign flag = s_q.flag;
endmodule

// *** design/sfs_supervisor.sv ***
/*
  Servo fault supervisor: watches drive conditions, latches numbered faults,
  exposes settings and fault state over AXI4-Lite.
  Assumes all condition inputs are synchronous to aclk.
*/
// Functional notes
// - Flag sync timeout when the next sync arrives later than the set period.
// - Flag locked rotor when current exceeds threshold at near-zero speed for duration.
// - Flag brake overload when continuous braking energy exceeds modelled dissipation.
// - Heat model uses resistance, rated power and coefficient settings; coefficient default 50.
// - Flag forward-limit-unassigned when homing needs it and no input holds it.
// - Flag reverse-limit-unassigned when homing needs it and no input holds it.
// - Flag origin-not-found when homing ends without seeing the origin input.
// - Flag bus-state fault when bus goes pre-operational while the drive enables.
// - Flag unsupported mode when the bus requests an unimplemented operating mode.
// - In absolute mode flag turn overflow when multi-turn count leaves its range.
// - Flag battery failure at first power-up after backup battery loss.
// - Battery fault clears on fault reset once the battery is back.
module sfs_supervisor
  import sfs_pkg::*;
#(
  parameter int DATA_W = 16,
  parameter int NUM_DI = 8,
  parameter int MS_CYC = SFS_MS_CYCLES
) (
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic [SFS_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [SFS_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  input  wire logic                  sync_event,
  input  wire logic [DATA_W-1:0]     drive_current_percent,
  input  wire logic [DATA_W-1:0]     motor_speed,
  input  wire logic                  braking_active,
  input  wire logic [DATA_W-1:0]     bus_voltage,
  input  wire logic [NUM_DI-1:0]     forward_limit_input_function,
  input  wire logic [NUM_DI-1:0]     reverse_limit_input_function,
  input  wire logic                  homing_active,
  input  wire logic                  homing_needs_fwd,
  input  wire logic                  homing_needs_rev,
  input  wire logic                  homing_done,
  input  wire logic                  origin_input,
  input  wire logic                  drive_enabling,
  input  wire logic                  bus_preop_switch,
  input  wire logic                  bus_mode_request,
  input  wire logic                  bus_mode_supported,
  input  wire logic                  turn_count_overflow,
  input  wire logic                  battery_lost,
  output logic                       fault_active,
  output logic [9:0]                 fault_code
);
  import sfs_pkg::*;

  // *****
  // State
  // *****
  typedef struct packed {
    sfs_bus_t    wst;
    sfs_bus_t    rst;
    logic        aw_got;
    logic        w_got;
    logic [7:0]  aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic [1:0]  bresp;
    logic [31:0] rdata;
    logic [1:0]  rresp;

    logic        freset;
    logic        abs_mode;
    logic [31:0] sync_period;
    logic [31:0] sync_cnt;
    logic        sync_armed;

    logic [15:0] stall_thr;
    logic [15:0] stall_ms;
    logic [15:0] speed_thr;
    logic [15:0] brake_ohms;
    logic [15:0] brake_power;
    logic [7:0]  brake_coef;
    logic [31:0] stall_cyc;
    logic [15:0] stall_cnt;
    logic [47:0] heat;
    logic        origin_seen;
    logic        homing_q;
    logic        powerup;
    logic [9:0]  code;
  } sfs_state_t;

  sfs_state_t s_q;
  sfs_state_t s_d;

  logic [SFS_NFAULT-1:0] cond;
  logic [SFS_NFAULT-1:0] flags;
  logic [DATA_W-1:0]     speed_abs;
  logic [47:0]           brake_in;
  logic [47:0]           brake_out;

  // *****
  // Fault conditions
  // *****
  assign speed_abs = motor_speed[DATA_W-1] ? DATA_W'(-motor_speed) : motor_speed;
  // Absorbed power V^2/R against rated power scaled by coefficient
  assign brake_in  = braking_active ?
                     48'(({16'h0000, bus_voltage} * {16'h0000, bus_voltage})
                         / {16'h0000, (s_q.brake_ohms | 16'h0001)}) : 48'h0;
  assign brake_out = (48'(s_q.brake_power) * 48'(s_q.brake_coef)) /
                     48'(SFS_COEF_RST);

  always_comb begin
    cond = '0;
    cond[SFS_F_SYNC]  = s_q.sync_armed && (s_q.sync_period != SFS_ZERO32) &&
                        (s_q.sync_cnt >= s_q.sync_period) && !sync_event;
    cond[SFS_F_STALL] = (s_q.stall_ms != SFS_STALL_RST) &&
                        (s_q.stall_cnt >= s_q.stall_ms);
    cond[SFS_F_BRAKE] = braking_active &&
                        (s_q.heat > 48'(s_q.brake_power) * 48'h3E8);
    cond[SFS_F_FWD]   = homing_active && homing_needs_fwd &&
                        (forward_limit_input_function == '0);
    cond[SFS_F_REV]   = homing_active && homing_needs_rev &&
                        (reverse_limit_input_function == '0);
    cond[SFS_F_ORG]   = homing_done && !(s_q.origin_seen || origin_input);
    cond[SFS_F_BUS]   = drive_enabling && bus_preop_switch;
    cond[SFS_F_MODE]  = bus_mode_request && !bus_mode_supported;
    cond[SFS_F_TURN]  = s_q.abs_mode && turn_count_overflow;
    cond[SFS_F_BATT]  = (s_q.powerup || flags[SFS_F_BATT]) &&
                        battery_lost;
  end

  // *****
  // Latched fault bits
  // *****
  genvar gi;
  generate
    for (gi = 0; gi < SFS_NFAULT; gi++) begin : g_flag
      sfs_sticky u_flag (
        .aclk        (aclk),
        .aresetn     (aresetn),
        .cond        (cond[gi]),
        .fault_reset (s_q.freset),
        .flag        (flags[gi])
      );
    end
  endgenerate

  // *****
  // Next state
  // *****
  always_comb begin
    s_d = s_q;
    s_d.freset  = 1'b0;
    s_d.powerup = 1'b0;
    // Sync period watchdog
    if (sync_event) begin
      s_d.sync_cnt   = SFS_ZERO32;
      s_d.sync_armed = 1'b1;
    end else if (s_q.sync_cnt != 32'hFFFF_FFFF) begin
      s_d.sync_cnt = s_q.sync_cnt + 32'h1;
    end

    // Stall timer in milliseconds
    if ((drive_current_percent > s_q.stall_thr) && (speed_abs <= s_q.speed_thr)) begin
      if (s_q.stall_cyc >= 32'(MS_CYC - 1)) begin
        s_d.stall_cyc = SFS_ZERO32;
        if (s_q.stall_cnt != 16'hFFFF) begin
          s_d.stall_cnt = s_q.stall_cnt + 16'h1;
        end
      end else begin
        s_d.stall_cyc = s_q.stall_cyc + 32'h1;
      end
    end else begin
      s_d.stall_cyc = SFS_ZERO32;
      s_d.stall_cnt = SFS_STALL_RST;
    end

    // Resistor heat integrator
    if (s_q.heat + brake_in > brake_out) begin
      s_d.heat = s_q.heat + brake_in - brake_out;
    end else begin
      s_d.heat = 48'h0;
    end

    // Origin tracking across a homing run
    s_d.homing_q = homing_active;
    if (homing_active && !s_q.homing_q) begin
      s_d.origin_seen = origin_input;
    end else if (origin_input) begin
      s_d.origin_seen = 1'b1;
    end

    // Highest-priority fault code
    s_d.code = SFS_CODE_NONE;
    for (int i = SFS_NFAULT - 1; i >= 0; i--) begin
      if (flags[i]) begin
        unique case (i)
          SFS_F_SYNC:  s_d.code = SFS_CODE_SYNC;
          SFS_F_STALL: s_d.code = SFS_CODE_STALL;
          SFS_F_BRAKE: s_d.code = SFS_CODE_BRAKE;
          SFS_F_FWD:   s_d.code = SFS_CODE_FWD;
          SFS_F_REV:   s_d.code = SFS_CODE_REV;
          SFS_F_ORG:   s_d.code = SFS_CODE_ORG;
          SFS_F_BUS:   s_d.code = SFS_CODE_BUS;
          SFS_F_MODE:  s_d.code = SFS_CODE_MODE;
          SFS_F_TURN:  s_d.code = SFS_CODE_TURN;
          SFS_F_BATT:  s_d.code = SFS_CODE_BATT;
          default:     s_d.code = SFS_CODE_NONE;
        endcase
      end
    end

    // Write channel
    unique case (s_q.wst)
      SFS_BUS_IDLE: begin
        if (s_axi_awvalid && !s_q.aw_got) begin
          s_d.aw_got  = 1'b1;
          s_d.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !s_q.w_got) begin
          s_d.w_got  = 1'b1;
          s_d.w_data = s_axi_wdata;
          s_d.w_strb = s_axi_wstrb;
        end
        if (s_q.aw_got && s_q.w_got) begin
          s_d.aw_got = 1'b0;
          s_d.w_got  = 1'b0;
          s_d.wst    = SFS_BUS_RESP;
          s_d.bresp  = SFS_RESP_OK;
          unique case (s_q.aw_addr)
            SFS_CTRL_OFS: begin
              if (s_q.w_strb[0]) begin
                s_d.freset   = s_q.w_data[SFS_CTRL_RESET_BIT];
                s_d.abs_mode = s_q.w_data[SFS_CTRL_ABS_BIT];
              end
            end
            SFS_SYNC_OFS: begin
              for (int b = 0; b < 4; b++) begin
                if (s_q.w_strb[b]) begin
                  s_d.sync_period[8*b +: 8] = s_q.w_data[8*b +: 8];
                end
              end
            end
            SFS_STALL_OFS: begin
              if (s_q.w_strb[0]) s_d.stall_thr = s_q.w_data[15:0];
              if (s_q.w_strb[2]) s_d.stall_ms  = s_q.w_data[31:16];
            end
            SFS_SPEED_OFS: begin
              if (s_q.w_strb[0]) s_d.speed_thr = s_q.w_data[15:0];
            end
            SFS_BRAKE_OFS: begin
              if (s_q.w_strb[0]) s_d.brake_ohms  = s_q.w_data[15:0];
              if (s_q.w_strb[2]) s_d.brake_power = s_q.w_data[31:16];
            end
            SFS_HOME_OFS: begin
              if (s_q.w_strb[0]) s_d.brake_coef = s_q.w_data[7:0];
            end
            SFS_STATUS_OFS, SFS_CODE_OFS, SFS_HEAT_OFS: s_d.bresp = SFS_RESP_OK;
            default: s_d.bresp = SFS_RESP_ERR;
          endcase
        end
      end
      SFS_BUS_RESP: begin
        if (s_axi_bready) begin
          s_d.wst = SFS_BUS_IDLE;
        end
      end
      default: s_d.wst = SFS_BUS_IDLE;
    endcase

    // Read channel
    unique case (s_q.rst)
      SFS_BUS_IDLE: begin
        if (s_axi_arvalid) begin
          s_d.rst   = SFS_BUS_RESP;
          s_d.rresp = SFS_RESP_OK;
          s_d.rdata = SFS_ZERO32;
          unique case (s_axi_araddr)
            SFS_CTRL_OFS:   s_d.rdata = {30'h0, s_q.abs_mode, 1'b0};
            SFS_STATUS_OFS: s_d.rdata = 32'(flags);
            SFS_CODE_OFS:   s_d.rdata = {22'h0, s_q.code};
            SFS_SYNC_OFS:   s_d.rdata = s_q.sync_period;
            SFS_STALL_OFS:  s_d.rdata = {s_q.stall_ms, s_q.stall_thr};
            SFS_SPEED_OFS:  s_d.rdata = {16'h0, s_q.speed_thr};
            SFS_BRAKE_OFS:  s_d.rdata = {s_q.brake_power, s_q.brake_ohms};
            SFS_HOME_OFS:   s_d.rdata = {24'h0, s_q.brake_coef};
            SFS_HEAT_OFS:   s_d.rdata = s_q.heat[47:16];
            default:        s_d.rresp = SFS_RESP_ERR;
          endcase
        end
      end
      SFS_BUS_RESP: begin
        if (s_axi_rready) begin
          s_d.rst = SFS_BUS_IDLE;
        end
      end
      default: s_d.rst = SFS_BUS_IDLE;
    endcase
  end

  // *****
  // Registers
  // *****
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q            <= '0;
      s_q.wst        <= SFS_BUS_IDLE;
      s_q.rst        <= SFS_BUS_IDLE;
      s_q.brake_coef <= SFS_COEF_RST;
      s_q.powerup    <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // *****
  // Outputs
  // *****
  assign s_axi_awready = (s_q.wst == SFS_BUS_IDLE) && !s_q.aw_got;
  assign s_axi_wready  = (s_q.wst == SFS_BUS_IDLE) && !s_q.w_got;
  assign s_axi_bvalid  = (s_q.wst == SFS_BUS_RESP);
  assign s_axi_bresp   = s_q.bresp;
  assign s_axi_arready = (s_q.rst == SFS_BUS_IDLE);
  assign s_axi_rvalid  = (s_q.rst == SFS_BUS_RESP);
  assign s_axi_rdata   = s_q.rdata;
  assign s_axi_rresp   = s_q.rresp;

  assign fault_active  = |flags;
  assign fault_code    = s_q.code;
endmodule

// *** sim/sfs_props_properties.sv ***
/*
  Port checker for the fault supervisor.
  Assumes one clock and a synchronous active-low reset.
*/
module sfs_props #(
  parameter int NUM_DI = 8
) (
  input wire logic              aclk,
  input wire logic              aresetn,
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic              s_axi_rvalid,
  input wire logic              s_axi_rready,
  input wire logic [31:0]       s_axi_rdata,
  input wire logic              s_axi_wvalid,
  input wire logic              s_axi_bvalid,
  input wire logic              s_axi_bready,
  input wire logic [1:0]        s_axi_bresp,
  input wire logic [NUM_DI-1:0] forward_limit_input_function,
  input wire logic [NUM_DI-1:0] reverse_limit_input_function,
  input wire logic              homing_active,
  input wire logic              homing_needs_fwd,
  input wire logic              homing_needs_rev,
  input wire logic              drive_enabling,
  input wire logic              bus_preop_switch,
  input wire logic              bus_mode_request,
  input wire logic              bus_mode_supported,
  input wire logic              battery_lost,
  input wire logic              fault_active,
  input wire logic [9:0]        fault_code
);
  timeunit 1ns;
  timeprecision 1ps;
  // *****
  // Sequences
  // *****
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence s_mode_bad;
    bus_mode_request && !bus_mode_supported;
  endsequence
  sequence s_fwd_bad;
    homing_active && homing_needs_fwd && (forward_limit_input_function == '0);
  endsequence
  sequence s_rev_bad;
    homing_active && homing_needs_rev && (reverse_limit_input_function == '0);
  endsequence
  sequence s_no_write;
    !s_axi_wvalid && !$past(s_axi_wvalid) && !s_axi_bvalid && !$past(s_axi_bvalid);
  endsequence
  // *****
  // Assertions
  // *****
  a_rd_answer: assert property (s_rd_take |=> s_axi_rvalid)
    else $error("read answer late");
  a_rd_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_wr_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_mode_flag: assert property (s_mode_bad |=> fault_active)
    else $error("mode fault missing");
  a_fwd_flag: assert property (s_fwd_bad |=> fault_active)
    else $error("forward limit fault missing");
  a_rev_flag: assert property (s_rev_bad |=> fault_active)
    else $error("reverse limit fault missing");
  a_bus_flag: assert property (drive_enabling && bus_preop_switch |=> fault_active)
    else $error("bus state fault missing");
  a_batt_flag: assert property ($rose(aresetn) && battery_lost |-> ##[1:3] fault_active)
    else $error("battery fault missing");
  a_hold_flag: assert property ((fault_active and s_no_write) |=> fault_active)
    else $error("fault dropped without reset");
  a_code_idle: assert property (!fault_active && !$past(fault_active) |-> fault_code == 10'h000)
    else $error("code without fault");
endmodule

bind sfs_supervisor sfs_props #(.NUM_DI(NUM_DI)) u_props (
  .aclk(aclk), .aresetn(aresetn), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .s_axi_rdata(s_axi_rdata), .s_axi_wvalid(s_axi_wvalid), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
  .forward_limit_input_function(forward_limit_input_function),
  .reverse_limit_input_function(reverse_limit_input_function),
  .homing_active(homing_active), .homing_needs_fwd(homing_needs_fwd),
  .homing_needs_rev(homing_needs_rev), .drive_enabling(drive_enabling),
  .bus_preop_switch(bus_preop_switch), .bus_mode_request(bus_mode_request),
  .bus_mode_supported(bus_mode_supported), .battery_lost(battery_lost),
  .fault_active(fault_active), .fault_code(fault_code));

// *** sim/sfs_bus_partner.sv ***
/*
  Fieldbus master model: periodic sync events, state switch on command.
  Assumes the bench sets the sync gap in clock cycles, 0 stops sync.
*/
module sfs_bus_partner (
  input wire logic       aclk,
  input wire logic [7:0] sync_gap,
  input wire logic       break_preop,
  output logic           sync_event,
  output logic           bus_preop_switch
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cnt_q = 8'h00;
  always @(posedge aclk) begin
    cnt_q <= (sync_gap == 8'h00 || cnt_q >= sync_gap - 8'h01) ? 8'h00 : cnt_q + 8'h01;
    sync_event <= (sync_gap != 8'h00) && (cnt_q == 8'h00);
    bus_preop_switch <= break_preop;
  end
endmodule

// *** sim/tb_servo_fault_supervisor.sv ***
/*
  Self-checking bench for the fault supervisor.
  Assumes the register map and bus timing of the design.
*/
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin bad_count++; \
  $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module tb_servo_fault_supervisor;
  import sfs_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic        s_axi_rready, sync_event, braking_active, homing_active, homing_needs_fwd;
  logic        homing_needs_rev, homing_done, origin_input, drive_enabling, bus_preop_switch;
  logic        bus_mode_request, bus_mode_supported, turn_count_overflow, battery_lost;
  logic        fault_active, break_preop;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, sync_gap, forward_limit_input_function;
  logic [7:0]  reverse_limit_input_function;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, eb;
  logic [15:0] drive_current_percent, motor_speed, bus_voltage;
  logic [9:0]  fault_code;
  logic [33:0] er;
  logic [33:0] rq[$];
  logic [1:0]  bq[$];
  int          bad_count = 0;
  int          checked = 0;
  int          cyc = 0;
  sfs_supervisor #(.MS_CYC(100)) dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .sync_event(sync_event),
    .drive_current_percent(drive_current_percent), .motor_speed(motor_speed),
    .braking_active(braking_active), .bus_voltage(bus_voltage),
    .forward_limit_input_function(forward_limit_input_function),
    .reverse_limit_input_function(reverse_limit_input_function),
    .homing_active(homing_active), .homing_needs_fwd(homing_needs_fwd),
    .homing_needs_rev(homing_needs_rev), .homing_done(homing_done),
    .origin_input(origin_input), .drive_enabling(drive_enabling),
    .bus_preop_switch(bus_preop_switch), .bus_mode_request(bus_mode_request),
    .bus_mode_supported(bus_mode_supported), .turn_count_overflow(turn_count_overflow),
    .battery_lost(battery_lost), .fault_active(fault_active), .fault_code(fault_code));
  sfs_bus_partner bus (.aclk(aclk), .sync_gap(sync_gap), .break_preop(break_preop),
    .sync_event(sync_event), .bus_preop_switch(bus_preop_switch));
  // *****
  // Bus tasks
  // *****
  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e = SFS_RESP_OK);
    logic aw;
    logic w;
    aw = 1'b1;
    w = 1'b1;
    @(posedge aclk);
    bq.push_back(e);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (aw || w) begin
      @(posedge aclk);
      if (aw && s_axi_awready) begin
        aw = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (w && s_axi_wready) begin
        w = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
    end
    while (!s_axi_bvalid) @(posedge aclk);
    s_axi_bready <= 1'b1;
    @(posedge aclk);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = SFS_RESP_OK);
    @(posedge aclk);
    rq.push_back({r, d});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    while (!s_axi_rvalid) @(posedge aclk);
    s_axi_rready <= 1'b1;
    @(posedge aclk);
    s_axi_rready <= 1'b0;
  endtask
  task automatic chk_st(input logic [31:0] s, input logic [9:0] c);
    rd(SFS_STATUS_OFS, s);
    rd(SFS_CODE_OFS, {22'h000000, c});
  endtask
  task automatic clr();
    wr(SFS_CTRL_OFS, 32'h0000_0001);
  endtask
  task automatic tally_and_finish();
    if (bad_count == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // *****
  // Clock, monitor, timeout
  // *****
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (s_axi_rvalid && s_axi_rready) begin
      er = rq.pop_front();
      `CHK({s_axi_rresp, s_axi_rdata}, er)
    end
    if (s_axi_bvalid && s_axi_bready) begin
      eb = bq.pop_front();
      `CHK(s_axi_bresp, eb)
    end
    if (cyc == 20000) begin
      bad_count++;
      tally_and_finish();
    end
  end
  // *****
  // Scenarios
  // *****
  initial begin
    void'($urandom(32'h464DDD1F));
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, braking_active,
     homing_active, homing_needs_fwd, homing_needs_rev, homing_done, origin_input,
     drive_enabling, bus_mode_request, bus_mode_supported, turn_count_overflow} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, drive_current_percent, motor_speed, bus_voltage,
     forward_limit_input_function, reverse_limit_input_function, sync_gap, break_preop} = '0;
    s_axi_wstrb = 4'hF;
    aresetn = 1'b0;
    battery_lost = 1'b1;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    tick(3);
    rd(SFS_HOME_OFS, 32'h0000_0032);
    clr();
    chk_st(32'h200, SFS_CODE_BATT);
    battery_lost <= 1'b0;
    clr();
    chk_st(32'h0, SFS_CODE_NONE);
    rd(8'h40, 32'h0, SFS_RESP_ERR);
    wr(8'h44, 32'h1, SFS_RESP_ERR);
    for (int i = 0; i < 2; i++) begin
      homing_active <= 1'b1;
      homing_needs_fwd <= (i == 0);
      homing_needs_rev <= (i == 1);
      {forward_limit_input_function, reverse_limit_input_function} <= '0;
      tick(3);
      clr();
      chk_st(32'h8 << i, i ? SFS_CODE_REV : SFS_CODE_FWD);
      forward_limit_input_function <= 8'h01 << ($urandom % 8);
      reverse_limit_input_function <= 8'h01 << ($urandom % 8);
      tick(2);
      clr();
      chk_st(32'h0, SFS_CODE_NONE);
    end
    for (int j = 0; j < 2; j++) begin
      homing_active <= 1'b0;
      tick(1);
      homing_active <= 1'b1;
      origin_input <= (j == 0);
      tick(3);
      origin_input <= 1'b0;
      homing_done <= 1'b1;
      tick(1);
      homing_done <= 1'b0;
      tick(2);
      chk_st(j ? 32'h20 : 32'h0, j ? SFS_CODE_ORG : SFS_CODE_NONE);
    end
    homing_active <= 1'b0;
    clr();
    for (int j = 0; j < 2; j++) begin
      bus_mode_supported <= (j == 0);
      drive_enabling <= (j == 1);
      bus_mode_request <= 1'b1;
      break_preop <= 1'b1;
      tick(1);
      bus_mode_request <= 1'b0;
      break_preop <= 1'b0;
      tick(3);
      chk_st(j ? 32'hC0 : 32'h0, j ? SFS_CODE_BUS : SFS_CODE_NONE);
    end
    drive_enabling <= 1'b0;
    clr();
    wr(SFS_SYNC_OFS, 32'h0000_0014);
    sync_gap <= 8'h12;
    tick(100);
    chk_st(32'h0, SFS_CODE_NONE);
    sync_gap <= 8'h16;
    tick(100);
    chk_st(32'h1, SFS_CODE_SYNC);
    sync_gap <= 8'h00;
    wr(SFS_SYNC_OFS, 32'h0);
    clr();
    wr(SFS_BRAKE_OFS, 32'h000A_0001);
    braking_active <= 1'b1;
    tick(20);
    chk_st(32'h0, SFS_CODE_NONE);
    bus_voltage <= 16'h0064;
    tick(20);
    chk_st(32'h4, SFS_CODE_BRAKE);
    braking_active <= 1'b0;
    clr();
    wr(SFS_SPEED_OFS, 32'h0000_0005);
    wr(SFS_STALL_OFS, 32'h0001_0032);
    motor_speed <= 16'hFFFD;
    drive_current_percent <= 16'h0033 + 16'($urandom % 200);
    tick(80);
    chk_st(32'h0, SFS_CODE_NONE);
    tick(20);
    chk_st(32'h2, SFS_CODE_STALL);
    drive_current_percent <= 16'h0000;
    clr();
    for (int j = 0; j < 2; j++) begin
      turn_count_overflow <= 1'b1;
      tick(1);
      turn_count_overflow <= 1'b0;
      tick(2);
      chk_st(j ? 32'h100 : 32'h0, j ? SFS_CODE_TURN : SFS_CODE_NONE);
      wr(SFS_CTRL_OFS, 32'h0000_0002);
    end
    tally_and_finish();
  end
endmodule
